/* rtl/uwe_pkg.sv */
package uwe_pkg;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_BAUD_HIGH  = 8'h70;
	localparam logic [7:0] IDX_BAUD_LOW   = 8'h71;
	localparam logic [7:0] IDX_CTRL_ONE   = 8'h72;
	localparam logic [7:0] IDX_CTRL_TWO   = 8'h73;
	localparam logic [7:0] IDX_STATUS_ONE = 8'h74;
	localparam logic [7:0] IDX_STATUS_TWO = 8'h75;
	localparam logic [7:0] IDX_DATA_HIGH  = 8'h76;
	localparam logic [7:0] IDX_DATA_LOW   = 8'h77;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_BAUD_HIGH = 8'h00;
	localparam logic [7:0] RST_BAUD_LOW  = 8'h04;
	localparam logic [7:0] RST_CTRL      = 8'h00;

	// ==========================================================
	// Field widths and timing
	localparam int DIV_W       = 13;
	localparam int OVERSAMPLE  = 16;
	localparam logic [3:0] PH_LAST   = 4'hF;
	localparam logic [3:0] PH_SMP_A  = 4'h7;
	localparam logic [3:0] PH_SMP_C  = 4'h9;
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [3:0] BITS_NINE  = 4'h9;
	localparam logic [3:0] FRAME_SHORT = 4'hA;
	localparam logic [3:0] FRAME_LONG  = 4'hB;

	// ==========================================================
	// Field layouts
	typedef struct packed {
		logic internal_loopback;
		logic pin_open_drain_select;
		logic unused;
		logic nine_bit;
		logic wake_by_address;
		logic idle_detect_type;
		logic parity_enable;
		logic parity_odd_select;
	} uwe_ctrl_one_t;

	typedef struct packed {
		logic tx_irq_en;
		logic tc_irq_en;
		logic rx_irq_en;
		logic idle_irq_en;
		logic tx_enable;
		logic rx_enable;
		logic sleep_until_wake;
		logic send_break;
	} uwe_ctrl_two_t;

	typedef struct packed {
		logic tx_empty;
		logic tx_complete;
		logic rx_full_flag;
		logic idle_flag;
		logic overrun_flag;
		logic noise_flag;
		logic framing_error_flag;
		logic parity_error_flag;
	} uwe_status_t;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uwe_rx_t;

endpackage

/* rtl/uwe_sci.sv */
// The APB register port was chosen for this implementation.
module uwe_sci (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Baud source ticks and clock-control select
	input  wire logic        pll_tick,
	input  wire logic        xtal_tick,
	input  wire logic        clock_source_select,
	// Serial pins
	input  wire logic        rx_pin_in,
	output logic             tx_pin_out,
	output logic             tx_pin_oe
);

	// ==========================================================
	// Registers
	logic [7:0]          baud_divider_high;
	logic [7:0]          baud_divider_low;
	uwe_pkg::uwe_ctrl_one_t line_control_one;
	uwe_pkg::uwe_ctrl_two_t line_control_two;
	logic                rx_full_flag;
	logic                idle_flag;
	logic                overrun_flag;
	logic                noise_flag;
	logic                framing_error_flag;
	logic                parity_error_flag;
	logic                tx_empty;
	uwe_pkg::uwe_status_t   seen;
	logic [8:0]          rx_data;
	logic [8:0]          tx_buf;

	// ==========================================================
	// Helpers
	function automatic logic majority(input logic [2:0] s);
		majority = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
	endfunction

	function automatic logic parity_of(input logic [8:0] d,
		input logic nine);
		parity_of = nine ? ^d : ^d[7:0];
	endfunction

	// ==========================================================
	// Bus decode
	wire logic [9:0] word_idx   = paddr[11:2];
	wire logic       setup      = psel & ~penable;
	wire logic       access     = psel & penable;
	wire logic       wr         = access & pwrite;
	wire logic       rd         = access & ~pwrite;
	wire logic       hit_bh     = word_idx == {2'h0, uwe_pkg::IDX_BAUD_HIGH};
	wire logic       hit_bl     = word_idx == {2'h0, uwe_pkg::IDX_BAUD_LOW};
	wire logic       hit_c1     = word_idx == {2'h0, uwe_pkg::IDX_CTRL_ONE};
	wire logic       hit_c2     = word_idx == {2'h0, uwe_pkg::IDX_CTRL_TWO};
	wire logic       hit_s1     = word_idx == {2'h0, uwe_pkg::IDX_STATUS_ONE};
	wire logic       hit_s2     = word_idx == {2'h0, uwe_pkg::IDX_STATUS_TWO};
	wire logic       hit_dh     = word_idx == {2'h0, uwe_pkg::IDX_DATA_HIGH};
	wire logic       hit_dl     = word_idx == {2'h0, uwe_pkg::IDX_DATA_LOW};
	wire logic       mapped     = hit_bh | hit_bl | hit_c1 | hit_c2 |
	                              hit_s1 | hit_s2 | hit_dh | hit_dl;
	wire logic       status_rd  = rd & hit_s1;
	wire logic       data_rd    = rd & (hit_dl | hit_dh);
	wire logic       data_lo_wr = wr & hit_dl;

	// ==========================================================
	// Baud generator: one sample tick per 2*BR source ticks
	wire logic [12:0] baud_divider = {baud_divider_high[4:0],
	                                  baud_divider_low};
	wire logic        src_tick = clock_source_select ? pll_tick
	                                                 : xtal_tick;
	wire logic        div_run  = baud_divider != 13'h0000;
	wire logic [13:0] div_top  = {baud_divider, 1'b0} - 14'h0001;
	logic [13:0] div_cnt;
	logic        smp_tick;

	// Counter held at zero, with no sample ticks, while the divider is zero
	always_ff @(posedge clk_sys) begin
		if (rst | ~div_run) begin
			div_cnt  <= 14'h0000;
			smp_tick <= 1'b0;
		end else begin
			smp_tick <= src_tick & (div_cnt >= div_top);
			if (src_tick)
				div_cnt <= (div_cnt >= div_top) ? 14'h0000
				                                : div_cnt + 14'h0001;
		end
	end

	// ==========================================================
	// Transmitter
	logic [10:0] tx_shift;
	logic [3:0]  tx_left;
	logic [3:0]  tx_phase;
	wire logic   tx_busy  = tx_left != 4'h0;
	wire logic   bit_tick = smp_tick & (tx_phase == uwe_pkg::PH_LAST);
	wire logic   nine     = line_control_one.nine_bit;
	wire logic   par_gen  = parity_of(tx_buf, nine) ^
	                        line_control_one.parity_odd_select;
	wire logic [8:0] tx_word = ~line_control_one.parity_enable ? tx_buf :
	                           nine ? {par_gen ^ tx_buf[8], tx_buf[7:0]} :
	                           {tx_buf[8], par_gen ^ tx_buf[7], tx_buf[6:0]};
	wire logic   tx_load  = bit_tick & ~tx_busy & ~tx_empty &
	                        line_control_two.tx_enable;
	wire logic   tx_line  = tx_busy ? tx_shift[0]
	                                : ~line_control_two.send_break;

	// Shift register, LSB first, stop bit loaded at the top, ones shift in from the top
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tx_shift <= 11'h7FF;
			tx_left  <= 4'h0;
			tx_phase <= 4'h0;
		end else begin
			if (smp_tick)
				tx_phase <= tx_phase + 4'h1;
			if (tx_load) begin
				tx_shift <= nine ? {1'b1, tx_word, 1'b0}
				                 : {2'b11, tx_word[7:0], 1'b0};
				tx_left  <= nine ? uwe_pkg::FRAME_LONG
				                 : uwe_pkg::FRAME_SHORT;
			end else if (bit_tick & tx_busy) begin
				tx_shift <= {1'b1, tx_shift[10:1]};
				tx_left  <= tx_left - 4'h1;
			end
		end
	end

	// Pin drive; loopback holds the line idle, open-drain never drives one
	wire logic pin_level = line_control_one.internal_loopback
	                       ? 1'b1 : tx_line;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tx_pin_out <= 1'b1;
			tx_pin_oe  <= 1'b0;
		end else begin
			tx_pin_out <= pin_level;
			tx_pin_oe  <= line_control_two.tx_enable &
			              (~line_control_one.pin_open_drain_select |
			               ~pin_level);
		end
	end

	// ==========================================================
	// Receiver sampling
	wire logic rx_line = line_control_one.internal_loopback
	                     ? tx_line : rx_pin_in;
	uwe_pkg::uwe_rx_t rx_state;
	logic [3:0]  rx_phase;
	logic [3:0]  rx_cnt;
	logic [2:0]  rx_smp;
	logic [8:0]  rx_shift;
	logic        rx_noise;
	logic        rx_prev;
	logic [3:0]  ones_cnt;
	logic        idle_armed;
	wire logic [3:0] nbits   = nine ? uwe_pkg::BITS_NINE
	                                : uwe_pkg::BITS_EIGHT;
	wire logic [3:0] flen    = nine ? uwe_pkg::FRAME_LONG
	                                : uwe_pkg::FRAME_SHORT;
	wire logic   rx_on      = line_control_two.rx_enable;
	wire logic   bit_end    = smp_tick & (rx_phase == uwe_pkg::PH_LAST);
	wire logic   bit_val    = majority(rx_smp);
	wire logic   bit_noisy  = ~(&rx_smp) & (|rx_smp);
	wire logic   start_edge = smp_tick & rx_on & rx_prev & ~rx_line &
	                          (rx_state == uwe_pkg::RX_IDLE);
	wire logic   last_data  = rx_cnt == nbits - 4'h1;
	wire logic   stop_end   = bit_end & (rx_state == uwe_pkg::RX_STOP);
	wire logic   sleeping   = line_control_two.sleep_until_wake;
	wire logic [8:0] rx_word = nine ? rx_shift
	                                : {1'b0, rx_shift[8:1]};
	wire logic   addr_mark  = bit_end & (rx_state == uwe_pkg::RX_DATA) &
	                          last_data & bit_val &
	                          line_control_one.wake_by_address;

	// Ones run: short mode counts inside a frame, long only after stop
	wire logic count_bit = bit_end & bit_val &
	                       ((rx_state == uwe_pkg::RX_IDLE) |
	                        (~line_control_one.idle_detect_type &
	                         (rx_state != uwe_pkg::RX_START)));
	wire logic zero_bit  = bit_end & ~bit_val;
	wire logic idle_evt  = count_bit & idle_armed &
	                       (ones_cnt == flen - 4'h1);

	// Frame state machine
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rx_state <= uwe_pkg::RX_IDLE;
			rx_phase <= 4'h0;
			rx_cnt   <= 4'h0;
			rx_smp   <= 3'b111;
			rx_shift <= 9'h000;
			rx_noise <= 1'b0;
			rx_prev  <= 1'b1;
		end else if (smp_tick) begin
			rx_prev  <= rx_line;
			rx_phase <= start_edge ? 4'h1 : rx_phase + 4'h1;
			if (rx_phase >= uwe_pkg::PH_SMP_A &&
			    rx_phase <= uwe_pkg::PH_SMP_C)
				rx_smp <= {rx_smp[1:0], rx_line};
			unique case (rx_state)
			uwe_pkg::RX_IDLE: begin
				rx_noise <= 1'b0;
				if (start_edge)
					rx_state <= uwe_pkg::RX_START;
			end
			uwe_pkg::RX_START: begin
				if (bit_end) begin
					rx_noise <= bit_noisy;
					rx_cnt   <= 4'h0;
					rx_state <= bit_val ? uwe_pkg::RX_IDLE
					                    : uwe_pkg::RX_DATA;
				end
			end
			uwe_pkg::RX_DATA: begin
				if (bit_end) begin
					rx_shift <= {bit_val, rx_shift[8:1]};
					rx_noise <= rx_noise | bit_noisy;
					rx_cnt   <= rx_cnt + 4'h1;
					if (last_data)
						rx_state <= uwe_pkg::RX_STOP;
				end
			end
			uwe_pkg::RX_STOP: begin
				if (bit_end)
					rx_state <= uwe_pkg::RX_IDLE;
			end
			endcase
		end
	end

	// Idle run counter, armed again only after the line was active
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ones_cnt   <= 4'h0;
			idle_armed <= 1'b0;
		end else begin
			if (start_edge | zero_bit)
				ones_cnt <= 4'h0;
			else if (count_bit & ones_cnt != flen)
				ones_cnt <= ones_cnt + 4'h1;
			if (start_edge)
				idle_armed <= 1'b1;
			else if (idle_evt)
				idle_armed <= 1'b0;
		end
	end

	// ==========================================================
	// Receive status flags
	wire logic par_bad  = line_control_one.parity_enable &
	                      (parity_of(rx_word, nine) ^
	                       line_control_one.parity_odd_select);
	wire logic accept   = stop_end & ~sleeping & rx_on;
	wire logic ovr_set  = accept & rx_full_flag;
	wire logic load_ok  = accept & ~rx_full_flag &
	                      ~framing_error_flag;
	wire logic frm_set  = load_ok & ~bit_val;
	wire logic nse_set  = load_ok & (rx_noise | bit_noisy);
	wire logic par_set  = load_ok & par_bad;
	wire logic idle_set = idle_evt & ~sleeping & rx_on;
	wire logic clr_go   = data_rd;

	// Status read arms each shown flag; data read clears armed receive flags, a data low write an armed tx_empty
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			seen <= '0;
		end else if (status_rd) begin
			seen <= prdata[7:0];
		end else if (clr_go | data_lo_wr) begin
			seen <= '0;
		end
	end

	// Set wins over the two-step clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rx_full_flag       <= 1'b0;
			idle_flag          <= 1'b0;
			overrun_flag       <= 1'b0;
			noise_flag         <= 1'b0;
			framing_error_flag <= 1'b0;
			parity_error_flag  <= 1'b0;
			rx_data            <= 9'h000;
		end else begin
			if (load_ok)
				rx_data <= rx_word;
			rx_full_flag <= load_ok |
			                (rx_full_flag & ~(clr_go & seen.rx_full_flag));
			idle_flag    <= idle_set |
			                (idle_flag & ~(clr_go & seen.idle_flag));
			overrun_flag <= ovr_set | (overrun_flag &
			                ~(clr_go & seen.overrun_flag));
			noise_flag   <= nse_set | (noise_flag &
			                ~(clr_go & seen.noise_flag));
			framing_error_flag <= frm_set | (framing_error_flag &
			                ~(clr_go & seen.framing_error_flag));
			parity_error_flag  <= par_set | (parity_error_flag &
			                ~(clr_go & seen.parity_error_flag));
		end
	end

	// ==========================================================
	// Control registers and transmit buffer
	wire logic wake_clr = (idle_evt & ~line_control_one.wake_by_address)
	                      | addr_mark;
	wire logic tdre_clr = data_lo_wr & seen.tx_empty;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			baud_divider_high <= uwe_pkg::RST_BAUD_HIGH;
			baud_divider_low  <= uwe_pkg::RST_BAUD_LOW;
			line_control_one  <= uwe_pkg::RST_CTRL;
			line_control_two  <= uwe_pkg::RST_CTRL;
			tx_buf            <= 9'h000;
			tx_empty          <= 1'b1;
		end else begin
			if (wr & hit_bh)
				baud_divider_high <= pwdata[7:0] & 8'hDF;
			if (wr & hit_bl)
				baud_divider_low <= pwdata[7:0];
			if (wr & hit_c1)
				line_control_one <= pwdata[7:0] & 8'hDF;
			// Hardware wake clears the sleep bit after any write
			if (wr & hit_c2)
				line_control_two <= pwdata[7:0];
			if (wake_clr)
				line_control_two.sleep_until_wake <= 1'b0;
			if (wr & hit_dh)
				tx_buf[8] <= pwdata[6];
			if (data_lo_wr)
				tx_buf[7:0] <= pwdata[7:0];
			tx_empty <= tx_load | (tx_empty & ~tdre_clr);
		end
	end

	// ==========================================================
	// Read mux; data registered in the setup phase, zero wait states
	uwe_pkg::uwe_status_t status_now;
	assign status_now = '{tx_empty, ~tx_busy & tx_empty, rx_full_flag,
	                      idle_flag, overrun_flag, noise_flag,
	                      framing_error_flag, parity_error_flag};
	wire logic [7:0] rd_byte =
		hit_bh ? baud_divider_high :
		hit_bl ? baud_divider_low :
		hit_c1 ? line_control_one :
		hit_c2 ? line_control_two :
		hit_s1 ? status_now :
		hit_s2 ? {7'h00, rx_state != uwe_pkg::RX_IDLE} :
		hit_dh ? {rx_data[8], tx_buf[8], 6'h00} :
		hit_dl ? rx_data[7:0] : 8'h00;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup) begin
				prdata  <= {24'h00_0000, rd_byte};
				pslverr <= ~mapped;
			end
		end
	end

endmodule

/* sim/uwe_node.sv */
module uwe_node #(
	parameter int BIT_CLKS = 32
) (
	// Clock
	input wire logic clk_sys,
	// Pull-down on the shared line
	output logic     drive_low
);
	timeunit 1ns;
	timeprecision 1ns;

	initial drive_low = 1'b0;

	// ==========================================================
	// Frame sender, LSB first; releasing lets the pull-up idle high
	// Glitch hits mid first data bit, one sample of three
	task automatic send(input logic [10:0] f, input int len,
		input logic glitch);
		logic b;
		for (int i = 0; i < len; i++) begin
			for (int c = 0; c < BIT_CLKS; c++) begin
				@(posedge clk_sys);
				b = f[i] ^ (glitch && i == 1 && (c == 18 || c == 19));
				drive_low <= !b;
			end
		end
		@(posedge clk_sys);
		drive_low <= 1'b0;
	endtask
endmodule

/* sim/uwe_sci_chk.sv */
module uwe_sci_chk (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst,
	// Register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Transmit pin
	input wire logic        tx_pin_out,
	input wire logic        tx_pin_oe
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Bus decode
	wire       acc    = psel && penable;
	wire [9:0] idx    = paddr[11:2];
	wire       in_map = idx >= {2'b00, uwe_pkg::IDX_BAUD_HIGH}
		&& idx <= {2'b00, uwe_pkg::IDX_DATA_LOW};
	wire       is_c1  = idx == {2'b00, uwe_pkg::IDX_CTRL_ONE};
	wire       is_c2  = idx == {2'b00, uwe_pkg::IDX_CTRL_TWO};
	wire       is_bl  = idx == {2'b00, uwe_pkg::IDX_BAUD_LOW};

	// Shadows of software writes; hardware wake can clear the sleep bit c2[1], which the shadow keeps
	logic [7:0] c1;
	logic [7:0] c2;
	logic [7:0] bl;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			c1 <= uwe_pkg::RST_CTRL;
			c2 <= uwe_pkg::RST_CTRL;
			bl <= uwe_pkg::RST_BAUD_LOW;
		end else if (acc && pwrite) begin
			if (is_c1) c1 <= pwdata[7:0];
			if (is_c2) c2 <= pwdata[7:0];
			if (is_bl) bl <= pwdata[7:0];
		end
	end

	// Pin modes; need two cycles since the pin is registered
	wire lp = c1[7] && c2[3];
	wire od = c1[6];
	wire pp = !c1[7] && !c1[6] && c2[3];

	// ==========================================================
	// Properties
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	AST_RESET_OUT: assert property ($past(rst) |->
		(!pready && tx_pin_out && !tx_pin_oe && prdata == 32'h0) ##1 pready)
		else $error("outputs wrong after reset");
	AST_PREADY: assert property (psel && !penable |=> pready)
		else $error("access phase without ready");
	AST_UNMAPPED: assert property (acc && !in_map |->
		pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	AST_MAPPED: assert property (acc && in_map |->
		!pslverr && prdata[31:8] == 24'h0)
		else $error("mapped access answered wrongly");
	AST_BAUD_RB: assert property (acc && !pwrite && is_bl |->
		prdata[7:0] == bl)
		else $error("baud low reads back wrong");
	AST_CTRL_RB: assert property (acc && !pwrite && is_c1 |->
		prdata[7:0] == (c1 & 8'hDF))
		else $error("control one reads back wrong");
	AST_LOOP_HIGH: assert property (lp && $past(lp) |->
		tx_pin_out && tx_pin_oe)
		else $error("pin not held high in loopback");
	AST_OD_LOW: assert property (od && $past(od) && tx_pin_oe |->
		!tx_pin_out)
		else $error("pin driven high in open drain");
	AST_PUSH_OE: assert property (pp && $past(pp) |-> tx_pin_oe)
		else $error("pin not driven in normal mode");
endmodule

bind uwe_sci uwe_sci_chk u_chk (.clk_sys, .rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .tx_pin_out, .tx_pin_oe);

/* sim/uwe_sci_tb_top.sv */
module uwe_sci_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Stimulus and observation
	logic        clk_sys             = 1'b0;
	logic        rst                 = 1'b1;
	logic        psel                = 1'b0;
	logic        penable             = 1'b0;
	logic        pwrite              = 1'b0;
	logic [11:0] paddr               = 12'h000;
	logic [31:0] pwdata              = 32'h0;
	logic        pll_tick            = 1'b1;
	logic        xtal_tick           = 1'b1;
	logic        clock_source_select = 1'b1;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        tx_pin_out;
	logic        tx_pin_oe;
	logic        node_low;
	logic        last_err;
	int          errors              = 0;
	int          num_checks          = 0;
	localparam logic [7:0] FULL = 8'h20;
	localparam logic [7:0] OVR  = 8'h08;
	localparam logic [7:0] NSE  = 8'h04;
	localparam logic [7:0] FRM  = 8'h02;
	localparam logic [7:0] PAR  = 8'h01;
	localparam logic [7:0] RXM  = 8'h2F;

	// Wired line: pull-up, any driver may pull low
	wire rx_line = !node_low && !(tx_pin_oe && !tx_pin_out);

	always #25 clk_sys = ~clk_sys;

	uwe_sci DUT (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .pll_tick, .xtal_tick,
		.clock_source_select, .rx_pin_in(rx_line), .tx_pin_out, .tx_pin_oe);
	uwe_node #(.BIT_CLKS(32)) u_node (.clk_sys, .drive_low(node_low));

	// ==========================================================
	// Bus and compare helpers
	task automatic give_verdict();
		$display("checks %0d, errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t ns: got %h expected %h",
				$time, got, exp);
		end
	endtask

	// Request held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] i,
		input logic [7:0] wd, output logic [7:0] rdv);
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {2'b00, i, 2'b00};
		pwdata  <= {24'h0, wd};
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rdv = prdata[7:0];
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] x;
		apb(1'b1, i, d, x);
	endtask

	task automatic rd(input logic [7:0] i, output logic [7:0] d);
		apb(1'b0, i, 8'h00, d);
	endtask

	task automatic rchk(input logic [7:0] i, m, e);
		logic [7:0] v;
		rd(i, v);
		chk(v & m, e);
	endtask

	// Two-step read, then flags must be gone
	task automatic take(input logic [7:0] st, input logic [7:0] dv);
		rchk(uwe_pkg::IDX_STATUS_ONE, RXM, st);
		rchk(uwe_pkg::IDX_DATA_LOW, 8'hFF, dv);
		rchk(uwe_pkg::IDX_STATUS_ONE, RXM, 8'h00);
	endtask

	function automatic logic [10:0] fr(input logic [8:0] d, input int n,
		input logic stop);
		logic [10:0] f;
		f = 11'h7FE;
		for (int i = 0; i < n; i++) f[i + 1] = d[i];
		f[n + 1] = stop;
		return f;
	endfunction

	// Frame from the far node, then time for the flags to land
	task automatic snd(input logic [8:0] d, input int n, input logic stop,
		input logic g);
		u_node.send(fr(d, n, stop), n + 2, g);
		repeat (40) @(posedge clk_sys);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		logic [7:0] v;
		rchk(uwe_pkg::IDX_BAUD_HIGH, 8'hFF, uwe_pkg::RST_BAUD_HIGH);
		rchk(uwe_pkg::IDX_BAUD_LOW, 8'hFF, uwe_pkg::RST_BAUD_LOW);
		rchk(uwe_pkg::IDX_CTRL_ONE, 8'hFF, uwe_pkg::RST_CTRL);
		rchk(uwe_pkg::IDX_STATUS_ONE, 8'hFF, 8'hC0);
		rd(8'h10, v);
		chk({7'h00, last_err}, 8'h01);
		chk(v, 8'h00);
		wr(uwe_pkg::IDX_BAUD_HIGH, 8'hFF);
		rchk(uwe_pkg::IDX_BAUD_HIGH, 8'hFF, 8'hDF);
		wr(uwe_pkg::IDX_BAUD_HIGH, 8'h00);
		wr(uwe_pkg::IDX_BAUD_LOW, 8'h01);
		wr(uwe_pkg::IDX_CTRL_TWO, 8'h0C);
		$display("registers done");
	endtask

	task automatic one(input logic [7:0] c, input logic [8:0] d, input int n,
		input logic [7:0] st);
		logic [7:0] v;
		wr(uwe_pkg::IDX_CTRL_ONE, c);
		snd(d, n, 1'b1, 1'b0);
		rd(uwe_pkg::IDX_DATA_HIGH, v);
		if (n == 9) chk(v & 8'h80, {d[8], 7'h00});
		take(st, d[7:0]);
	endtask

	task automatic t_fmt();
		one(8'h00, 9'h05A, 8, FULL);
		one(8'h10, 9'h1A5, 9, FULL);
		one(8'h02, 9'h001, 8, FULL | PAR);
		one(8'h03, 9'h001, 8, FULL);
		one(8'h03, 9'h003, 8, FULL | PAR);
		one(8'h02, 9'h003, 8, FULL);
		wr(uwe_pkg::IDX_CTRL_ONE, 8'h00);
		snd(9'h05A, 8, 1'b1, 1'b1);
		take(FULL | NSE, 8'h5A);
		$display("formats done");
	endtask

	task automatic t_err();
		snd(9'h011, 8, 1'b1, 1'b0);
		snd(9'h022, 8, 1'b0, 1'b0);
		rchk(uwe_pkg::IDX_DATA_LOW, 8'hFF, 8'h11);
		take(FULL | OVR, 8'h11);
		snd(9'h033, 8, 1'b0, 1'b0);
		snd(9'h044, 8, 1'b1, 1'b0);
		rchk(uwe_pkg::IDX_STATUS_ONE, 8'h27, FULL | FRM);
		take(FULL | OVR | FRM, 8'h33);
		$display("errors done");
	endtask

	task automatic t_sleep();
		wr(uwe_pkg::IDX_CTRL_ONE, 8'h08);
		wr(uwe_pkg::IDX_CTRL_TWO, 8'h0E);
		wr(uwe_pkg::IDX_CTRL_TWO, 8'h0C);
		rchk(uwe_pkg::IDX_CTRL_TWO, 8'hFF, 8'h0C);
		wr(uwe_pkg::IDX_CTRL_TWO, 8'h0E);
		snd(9'h015, 8, 1'b0, 1'b0);
		rchk(uwe_pkg::IDX_STATUS_ONE, RXM, 8'h00);
		rchk(uwe_pkg::IDX_CTRL_TWO, 8'hFF, 8'h0E);
		snd(9'h095, 8, 1'b1, 1'b0);
		rchk(uwe_pkg::IDX_CTRL_TWO, 8'hFF, 8'h0C);
		take(FULL, 8'h95);
		wr(uwe_pkg::IDX_CTRL_ONE, 8'h00);
		wr(uwe_pkg::IDX_CTRL_TWO, 8'h0E);
		snd(9'h015, 8, 1'b1, 1'b0);
		rchk(uwe_pkg::IDX_STATUS_ONE, RXM, 8'h00);
		rchk(uwe_pkg::IDX_CTRL_TWO, 8'hFF, 8'h0E);
		repeat (400) @(posedge clk_sys);
		rchk(uwe_pkg::IDX_CTRL_TWO, 8'hFF, 8'h0C);
		$display("wakeup done");
	endtask

	task automatic t_clk();
		clock_source_select <= 1'b0;
		pll_tick            <= 1'b0;
		snd(9'h066, 8, 1'b1, 1'b0);
		take(FULL, 8'h66);
		clock_source_select <= 1'b1;
		snd(9'h077, 8, 1'b1, 1'b0);
		rchk(uwe_pkg::IDX_STATUS_ONE, RXM, 8'h00);
		pll_tick <= 1'b1;
		wr(uwe_pkg::IDX_BAUD_LOW, 8'h00);
		snd(9'h078, 8, 1'b1, 1'b0);
		rchk(uwe_pkg::IDX_STATUS_ONE, RXM, 8'h00);
		wr(uwe_pkg::IDX_BAUD_LOW, 8'h01);
		$display("clocking done");
	endtask

	// Own transmitter heard through loopback, open drain, push-pull
	task automatic t_tx();
		logic [7:0] v;
		logic [7:0] m [3] = '{8'h80, 8'h40, 8'h00};
		for (int i = 0; i < 3; i++) begin
			wr(uwe_pkg::IDX_CTRL_ONE, m[i]);
			rd(uwe_pkg::IDX_STATUS_ONE, v);
			wr(uwe_pkg::IDX_DATA_HIGH, 8'h00);
			wr(uwe_pkg::IDX_DATA_LOW, 8'h3C ^ m[i]);
			repeat (450) @(posedge clk_sys);
			take(FULL, 8'h3C ^ m[i]);
		end
		$display("transmit done");
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs();
		t_fmt();
		t_err();
		t_sleep();
		t_clk();
		t_tx();
		give_verdict();
	end

	// Watchdog: the run needs well under half this span
	initial begin
		repeat (40000) @(posedge clk_sys);
		errors++;
		give_verdict();
	end
endmodule
